//--- mds_regs.vh
/*
 * register offsets, field positions, reset values and timing counts for
 * the measurement data store. assumes a 40 MHz pclk and an APB master.
 */
// Function
// - result memory holds up to 5000 entries, one per completed result
// - two capture modes, normal and burst, chosen by a config bit
// - in normal mode a capture toggle turns storing on and off
// - leaving burst for normal forces capture off
// - display follows every result in normal, only when idle in burst
// - latest-result read served in normal mode, refused in burst
// - memory full sets status bit 10 and flashes the capture lamp
// - normal mode full: stop writing, measurement keeps running
// - burst mode full: halt, sweep to stop, dc or pulse to hold
// - verdict lines and buzzer driven live in normal, not in burst
// - burst mode verdict display refreshed only when idle
// - stored results readable by recall and indexed read in both modes
// - capture and mode changes ignored in free run or sweep operate
// - memory emptied on clear, capture on, mode switch, power on
`ifndef MDS_REGS_VH
`define MDS_REGS_VH
`define MDS_DEPTH 13'd5000
`define MDS_AW 13
`define MDS_DW 24
// byte offsets
`define MDS_OFS_CTRL 12'h000
`define MDS_OFS_CMD 12'h004
`define MDS_OFS_STAT 12'h008
`define MDS_OFS_EVT 12'h00C
`define MDS_OFS_MASK 12'h010
`define MDS_OFS_COUNT 12'h014
`define MDS_OFS_RIDX 12'h018
`define MDS_OFS_RDATA 12'h01C
`define MDS_OFS_LATEST 12'h020
// ctrl fields
`define MDS_CTRL_BURST 0
// cmd fields (write one to act)
`define MDS_CMD_TOGGLE 0
`define MDS_CMD_CLEAR 1
// event status fields
`define MDS_EVT_FULL 10
`define MDS_EVT_REFUSED 0
`define MDS_EVT_HALT 1
`define MDS_EVT_W 11
`define MDS_MASK_RST 11'h000
// lamp flash half period, 250 ms at 40 MHz
`define MDS_FLASH_MS 250
`define MDS_CLK_KHZ 40000
`define MDS_FLASH_CYC (`MDS_FLASH_MS * `MDS_CLK_KHZ)
`endif

//--- mds_mem.v
/*
 * result memory: one write port, one registered read port.
 * assumes both ports on pclk; no reset on the array contents.
 */
`include "mds_regs.vh"
module mds_mem (
  input wire pclk,
  input wire we,
  input wire [`MDS_AW-1:0] waddr,
  input wire [`MDS_DW-1:0] wdata,
  input wire [`MDS_AW-1:0] raddr,
  output reg [`MDS_DW-1:0] rdata
);
  reg [`MDS_DW-1:0] mem [0:4999];

  // ===========================================================
  // storage
  always @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // mds_mem

//--- mds_store.v
/*
 * measurement data store: capture control, result memory, full handling,
 * display and verdict gating, APB register slave and interrupt.
 * assumes the engine and status inputs arrive from outside pclk; result_tgl and
 * the status inputs are synchronised here, result_data and verdict_in are not;
 * result_tgl is a level toggled once per result.
 */
// The placing of the registers and register access over APB were chosen for this implementation.
`include "mds_regs.vh"
module mds_store #(
  parameter FLASH_CYC = `MDS_FLASH_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg irq,
  input wire result_tgl,
  input wire [`MDS_DW-1:0] result_data,
  input wire [2:0] verdict_in,
  input wire meas_idle,
  input wire free_run,
  input wire sweep_operate,
  input wire sweep_source_mode,
  output reg [`MDS_DW-1:0] display_value,
  output reg [2:0] display_verdict,
  output reg [2:0] comparator_verdict_lines,
  output reg buzzer,
  output reg capture_indicator_lamp,
  output reg memory_full_flag,
  output reg sweep_stop,
  output reg source_hold
);
  // ===========================================================
  // synchronisers, first stage read only by second
  reg [2:0] tgl_s_q;
  reg idle_s1_q, idle_s2_q, free_s1_q, free_s2_q;
  reg swo_s1_q, swo_s2_q, swm_s1_q, swm_s2_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgl_s_q <= 3'h0;
      idle_s1_q <= 1'b0;
      idle_s2_q <= 1'b0;
      free_s1_q <= 1'b0;
      free_s2_q <= 1'b0;
      swo_s1_q <= 1'b0;
      swo_s2_q <= 1'b0;
      swm_s1_q <= 1'b0;
      swm_s2_q <= 1'b0;
    end else begin
      tgl_s_q <= {tgl_s_q[1:0], result_tgl};
      idle_s1_q <= meas_idle;
      idle_s2_q <= idle_s1_q;
      free_s1_q <= free_run;
      free_s2_q <= free_s1_q;
      swo_s1_q <= sweep_operate;
      swo_s2_q <= swo_s1_q;
      swm_s1_q <= sweep_source_mode;
      swm_s2_q <= swm_s1_q;
    end
  end
  // data and verdict are stable by the time the toggle is seen twice
  wire result_evt = tgl_s_q[2] ^ tgl_s_q[1];

  // ===========================================================
  // apb decode
  wire acc = psel & penable;
  // act only on the completing edge, so a command fires once per transfer
  wire done = acc & pready;
  wire wr = done & pwrite;
  wire rd = done & ~pwrite;
  function hit;
    input [11:0] a;
    input [11:0] o;
    begin
      hit = (a == o);
    end
  endfunction

  // ===========================================================
  // capture state
  reg burst_q, capture_q, full_q;
  reg [`MDS_AW-1:0] widx_q;
  reg [`MDS_DW-1:0] latest_q;
  reg [2:0] verdict_q;
  reg [`MDS_AW-1:0] ridx_q;
  wire [`MDS_DW-1:0] mem_rdata;
  // changes frozen while free run or sweep operate is on
  wire locked = free_s2_q | swo_s2_q;
  wire ctrl_wr = wr & hit(paddr, `MDS_OFS_CTRL);
  wire cmd_wr = wr & hit(paddr, `MDS_OFS_CMD);
  wire new_burst = pwdata[`MDS_CTRL_BURST];
  wire mode_chg = ctrl_wr & ~locked & (new_burst != burst_q);
  wire tog_req = cmd_wr & pwdata[`MDS_CMD_TOGGLE] & ~locked;
  wire tog = tog_req & ~burst_q;
  wire turn_on = tog & ~capture_q;
  wire clr_cmd = cmd_wr & pwdata[`MDS_CMD_CLEAR];
  wire clr = clr_cmd | turn_on | mode_chg;
  wire store = result_evt & capture_q & ~full_q;
  wire at_cap = (widx_q == `MDS_DEPTH - 13'd1);

  // mode, capture flag and write index
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      burst_q <= 1'b0;
      capture_q <= 1'b0;
      widx_q <= {`MDS_AW{1'b0}};
      full_q <= 1'b0;
    end else begin
      if (mode_chg) begin
        burst_q <= new_burst;
        // leaving burst drops capture; entering burst starts it
        capture_q <= new_burst;
      end else if (tog) begin
        capture_q <= ~capture_q;
      end
      if (clr) begin
        widx_q <= {`MDS_AW{1'b0}};
        full_q <= 1'b0;
      end else if (store) begin
        widx_q <= widx_q + 13'd1;
        full_q <= at_cap;
      end
    end
  end

  mds_mem u_mem (
    .pclk(pclk),
    .we(store),
    .waddr(widx_q),
    .wdata(result_data),
    .raddr(ridx_q),
    .rdata(mem_rdata)
  );

  // ===========================================================
  // display, verdict and halt outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latest_q <= {`MDS_DW{1'b0}};
      verdict_q <= 3'h0;
      display_value <= {`MDS_DW{1'b0}};
      display_verdict <= 3'h0;
      comparator_verdict_lines <= 3'h0;
      buzzer <= 1'b0;
      sweep_stop <= 1'b0;
      source_hold <= 1'b0;
    end else begin
      if (result_evt) begin
        latest_q <= result_data;
        verdict_q <= verdict_in;
      end
      // burst defers the panel until the engine is idle
      if (!burst_q && result_evt) begin
        display_value <= result_data;
        display_verdict <= verdict_in;
      end else if (burst_q && idle_s2_q) begin
        display_value <= latest_q;
        display_verdict <= verdict_q;
      end
      if (!burst_q) begin
        if (result_evt) begin
          comparator_verdict_lines <= verdict_in;
          buzzer <= verdict_in[2] | verdict_in[0];
        end
      end else begin
        comparator_verdict_lines <= 3'h0;
        buzzer <= 1'b0;
      end
      // halt held while burst and full; released by clear
      sweep_stop <= burst_q & full_q & swm_s2_q;
      source_hold <= burst_q & full_q & ~swm_s2_q;
    end
  end

  // ===========================================================
  // lamp flash divider, on while capturing, blinking when full
  localparam [31:0] FLASH_TOP = FLASH_CYC - 1;
  reg [31:0] fcnt_q;
  reg blink_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcnt_q <= 32'h0;
      blink_q <= 1'b0;
      capture_indicator_lamp <= 1'b0;
      memory_full_flag <= 1'b0;
    end else begin
      if (fcnt_q == FLASH_TOP) begin
        fcnt_q <= 32'h0;
        blink_q <= ~blink_q;
      end else begin
        fcnt_q <= fcnt_q + 32'h1;
      end
      capture_indicator_lamp <= full_q ? blink_q : capture_q;
      memory_full_flag <= full_q;
    end
  end

  // ===========================================================
  // event status and mask; read of status clears, set wins
  reg [`MDS_EVT_W-1:0] evt_q, mask_q;
  wire full_rise = store & at_cap;
  wire refuse = rd & hit(paddr, `MDS_OFS_LATEST) & burst_q;
  wire [`MDS_EVT_W-1:0] evt_set = {full_rise, 8'h00,
    full_rise & burst_q, refuse};
  wire evt_rd = rd & hit(paddr, `MDS_OFS_EVT) & pready;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_q <= 11'h000;
      mask_q <= `MDS_MASK_RST;
      ridx_q <= {`MDS_AW{1'b0}};
      irq <= 1'b0;
    end else begin
      evt_q <= (evt_rd ? 11'h000 : evt_q) | evt_set;
      if (wr && hit(paddr, `MDS_OFS_MASK)) begin
        mask_q <= pwdata[`MDS_EVT_W-1:0];
      end
      if (wr && hit(paddr, `MDS_OFS_RIDX)) begin
        ridx_q <= pwdata[`MDS_AW-1:0];
      end
      irq <= |(evt_q & mask_q);
    end
  end

  // ===========================================================
  // apb answer: one wait state so the memory read settles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc & ~pready;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (acc && !pready) begin
        if (hit(paddr, `MDS_OFS_CTRL)) begin
          prdata <= {31'h0, burst_q};
        end else if (hit(paddr, `MDS_OFS_STAT)) begin
          prdata <= {29'h0, full_q, capture_q, burst_q};
        end else if (hit(paddr, `MDS_OFS_EVT)) begin
          prdata <= {21'h0, evt_q};
        end else if (hit(paddr, `MDS_OFS_MASK)) begin
          prdata <= {21'h0, mask_q};
        end else if (hit(paddr, `MDS_OFS_COUNT)) begin
          prdata <= {19'h0, widx_q};
        end else if (hit(paddr, `MDS_OFS_RIDX)) begin
          prdata <= {19'h0, ridx_q};
        end else if (hit(paddr, `MDS_OFS_RDATA)) begin
          prdata <= {8'h00, mem_rdata};
        end else if (hit(paddr, `MDS_OFS_LATEST)) begin
          prdata <= burst_q ? 32'h0 : {8'h00, latest_q};
          pslverr <= burst_q;
        end else if (!hit(paddr, `MDS_OFS_CMD)) begin
          pslverr <= 1'b1;
        end
      end
    end
  end
endmodule // mds_store

//--- mds_store_chk.sv
/* port checker for mds_store.
   assumes it is bound to the store with the same FLASH_CYC. */
module mds_store_chk #(
  parameter FLASH_CYC = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire buzzer,
  input wire [2:0] comparator_verdict_lines,
  input wire capture_indicator_lamp,
  input wire memory_full_flag,
  input wire sweep_stop,
  input wire source_hold
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // lamp watch
  logic [31:0] still_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a lamp frozen while full means no flashing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) still_q <= 32'h0;
    else if (!memory_full_flag || $changed(capture_indicator_lamp))
      still_q <= 32'h0;
    else still_q <= still_q + 32'h1;
  end
  // ==========
  // properties
  wait_state_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held");
  err_ack_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  latest_refuse_a: assert property (psel && penable && pready && !pwrite
    && paddr == 12'h020 && (sweep_stop || source_hold)
    |-> pslverr && prdata == 32'h0) else $error("latest served in burst");
  halt_full_a: assert property ((sweep_stop || source_hold)
    |-> memory_full_flag) else $error("halt without full");
  halt_one_a: assert property (!(sweep_stop && source_hold))
    else $error("stop and hold together");
  burst_quiet_a: assert property ((sweep_stop || source_hold)
    |-> comparator_verdict_lines == 3'h0 && !buzzer)
    else $error("verdict driven in burst");
  lamp_flash_a: assert property (still_q <= FLASH_CYC + 2)
    else $error("lamp not flashing");
  full_clear_a: assert property ($fell(memory_full_flag)
    |-> $past(psel && pwrite) || $past(psel && pwrite, 2))
    else $error("full dropped without command");
  cover property ($rose(memory_full_flag));
  cover property ($rose(sweep_stop));
  cover property ($rose(source_hold));
  cover property (pslverr);
endmodule // mds_store_chk

//--- mds_engine_model.sv
/* measurement engine model: one result per fire request.
   assumes fire is a one-cycle level from the bench on pclk. */
module mds_engine_model #(
  parameter GAP = 8
) (
  input wire pclk,
  input wire fire,
  input wire [23:0] value,
  input wire [2:0] verdict,
  output logic result_tgl = 1'b0,
  output logic [23:0] result_data = 24'h0,
  output logic [2:0] verdict_in = 3'h0,
  output logic busy = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt = 8'h0;
  // data settles two cycles before the toggle; afterwards it is scrambled
  always @(posedge pclk) begin
    if (fire && !busy) begin
      busy <= 1'b1;
      cnt <= GAP;
      result_data <= value;
      verdict_in <= verdict;
    end else if (busy) begin
      cnt <= cnt - 8'h1;
      if (cnt == GAP - 1) result_tgl <= ~result_tgl;
      if (cnt == 8'h0) begin
        busy <= 1'b0;
        result_data <= ~result_data;
        verdict_in <= ~verdict_in;
      end
    end
  end
endmodule // mds_engine_model

//--- mds_store_tb.sv
/* self-checking bench for mds_store with an engine model.
   assumes a 40 MHz pclk and the store's one-wait APB answer. */
`include "mds_regs.vh"
module mds_store_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam FLASH_CYC = 8;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, q;
  logic e, fire = 0, meas_idle = 0, free_run = 0;
  logic sweep_operate = 0, sweep_source_mode = 0;
  logic [23:0] value = 24'h0;
  logic [2:0] verdict = 3'h0;
  wire [31:0] prdata;
  wire pready, pslverr, irq, result_tgl, busy, buzzer;
  wire capture_indicator_lamp, memory_full_flag, sweep_stop, source_hold;
  wire [23:0] result_data, display_value;
  wire [2:0] verdict_in, display_verdict, comparator_verdict_lines;
  integer mismatches = 0, num_checks = 0, cycles = 0, i;
  mds_store #(.FLASH_CYC(FLASH_CYC)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .result_tgl(result_tgl), .result_data(result_data),
    .verdict_in(verdict_in), .meas_idle(meas_idle), .free_run(free_run),
    .sweep_operate(sweep_operate), .sweep_source_mode(sweep_source_mode),
    .display_value(display_value), .display_verdict(display_verdict),
    .comparator_verdict_lines(comparator_verdict_lines), .buzzer(buzzer),
    .capture_indicator_lamp(capture_indicator_lamp),
    .memory_full_flag(memory_full_flag), .sweep_stop(sweep_stop),
    .source_hold(source_hold));
  mds_engine_model eng (.pclk(pclk), .fire(fire), .value(value),
    .verdict(verdict), .result_tgl(result_tgl), .result_data(result_data),
    .verdict_in(verdict_in), .busy(busy));
  // ==========
  // clock and hang guard
  always #12.5 pclk = ~pclk;
  // full fill needs about 65k cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      mismatches = mismatches + 1;
      test_done;
    end
  end
  // ==========
  // tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  // request held until pready is seen high at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer n;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin @(posedge pclk); n = n + 1; end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk(q, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  task send(input logic [23:0] v, input logic [2:0] vd);
    fire <= 1; value <= v; verdict <= vd;
    @(posedge pclk);
    fire <= 0;
    repeat (12) @(posedge pclk);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========
  // scenarios
  task t_normal;
    rd(`MDS_OFS_COUNT, 32'h0, 0);
    rd(12'h024, 32'h0, 1);
    send(24'hA5C3E1, 3'b010);
    chk(display_value, 24'hA5C3E1);
    chk(comparator_verdict_lines, 3'b010);
    rd(`MDS_OFS_LATEST, 32'hA5C3E1, 0);
    rd(`MDS_OFS_COUNT, 32'h0, 0);
    apb(1'b1, `MDS_OFS_CMD, 32'h1);
    send(24'h123456, 3'b100);
    chk(buzzer, 1'b1);
    chk(capture_indicator_lamp, 1'b1);
    rd(`MDS_OFS_COUNT, 32'h1, 0);
    apb(1'b1, `MDS_OFS_CMD, 32'h1);
    send(24'hA5C3E1, 3'b010);
    rd(`MDS_OFS_COUNT, 32'h1, 0);
    $display("normal done");
  endtask
  task t_burst;
    apb(1'b1, `MDS_OFS_CTRL, 32'h1);
    rd(`MDS_OFS_STAT, 32'h3, 0);
    for (i = 1; i < 4; i = i + 1) send(24'h000101 * i, 3'b100);
    chk(comparator_verdict_lines, 3'b000);
    chk(display_value, 24'hA5C3E1);
    rd(`MDS_OFS_COUNT, 32'h3, 0);
    apb(1'b1, `MDS_OFS_RIDX, 32'h1);
    rd(`MDS_OFS_RDATA, 32'h000202, 0);
    rd(`MDS_OFS_LATEST, 32'h0, 1);
    rd(`MDS_OFS_EVT, 32'h1, 0);
    meas_idle <= 1;
    repeat (6) @(posedge pclk);
    chk(display_value, 24'h000303);
    chk(display_verdict, 3'b100);
    meas_idle <= 0;
    free_run <= 1;
    repeat (4) @(posedge pclk);
    apb(1'b1, `MDS_OFS_CTRL, 32'h0);
    rd(`MDS_OFS_STAT, 32'h3, 0);
    free_run <= 0; sweep_operate <= 1;
    repeat (4) @(posedge pclk);
    apb(1'b1, `MDS_OFS_CTRL, 32'h0);
    rd(`MDS_OFS_STAT, 32'h3, 0);
    apb(1'b1, `MDS_OFS_CMD, 32'h2);
    rd(`MDS_OFS_COUNT, 32'h0, 0);
    sweep_operate <= 0;
    $display("burst done");
  endtask
  task t_full;
    sweep_source_mode <= 1;
    apb(1'b1, `MDS_OFS_MASK, 32'h400);
    apb(1'b1, `MDS_OFS_CMD, 32'h2);
    rd(`MDS_OFS_COUNT, 32'h0, 0);
    for (i = 0; i < 5001; i = i + 1) send(i[23:0], 3'b001);
    chk(memory_full_flag, 1'b1);
    chk({sweep_stop, source_hold}, 2'b10);
    rd(`MDS_OFS_COUNT, 32'd5000, 0);
    apb(1'b1, `MDS_OFS_RIDX, 32'd4999);
    rd(`MDS_OFS_RDATA, 32'd4999, 0);
    chk(irq, 1'b1);
    rd(`MDS_OFS_EVT, 32'h402, 0);
    sweep_source_mode <= 0;
    repeat (6) @(posedge pclk);
    chk(irq, 1'b0);
    chk({sweep_stop, source_hold}, 2'b01);
    apb(1'b1, `MDS_OFS_CMD, 32'h2);
    repeat (3) @(posedge pclk);
    chk({memory_full_flag, source_hold}, 2'b00);
    apb(1'b1, `MDS_OFS_CTRL, 32'h0);
    rd(`MDS_OFS_STAT, 32'h0, 0);
    $display("full done");
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_normal;
    t_burst;
    t_full;
    test_done;
  end
endmodule // mds_store_tb
bind mds_store mds_store_chk #(.FLASH_CYC(FLASH_CYC)) chk_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .buzzer(buzzer), .comparator_verdict_lines(comparator_verdict_lines),
  .capture_indicator_lamp(capture_indicator_lamp),
  .memory_full_flag(memory_full_flag), .sweep_stop(sweep_stop),
  .source_hold(source_hold));
